/* scnr_map.vh */
`ifndef SCNR_MAP_VH
`define SCNR_MAP_VH

// ----------------------------------------------------------------
// Configuration store layout
// ----------------------------------------------------------------
`define SCNR_CFG_AW          3
`define SCNR_CFG_DW          8
`define SCNR_CFG_DEPTH       8
`define SCNR_CFG_RST         8'h00
`define SCNR_ADDR_GAIN       3'h5
`define SCNR_ADDR_GAINSRC    3'h6
`define SCNR_BIT_GAINSRC     7

// ----------------------------------------------------------------
// Serial frame layout: header byte then data byte, MSB first
// ----------------------------------------------------------------
`define SCNR_FRAME_BITS      5'h10
`define SCNR_HDR_BITS        5'h08
`define SCNR_HDR_RW_BIT      7
`define SCNR_HDR_ADDR_MSB    2

// ----------------------------------------------------------------
// Data path widths and timing counts
// ----------------------------------------------------------------
`define SCNR_COEF_W          8
`define SCNR_PIX_W           10
`define SCNR_FIFO_DEPTH      4
`define SCNR_PIX_DIV         8
`define SCNR_PIX_CNT_W       8

`endif

/* scnr_fifo.v */
`default_nettype none

module scnr_fifo #(
	parameter W     = 10,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire         clk_in,        // Master clock
	input  wire         rst_n_in,      // Async reset, active low
	input  wire         in_valid_in,   // Write request
	output wire         in_ready_out,  // Space available
	input  wire [W-1:0] in_data_in,    // Write data
	output wire         out_valid_out, // Data available
	input  wire         out_ready_in,  // Drain accepts
	output wire [W-1:0] out_data_out   // Head word
);

	reg [W-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0]   count_reg;
	wire         push;
	wire         pop;

	function [AW-1:0] ptr_inc;
		input [AW-1:0] p;
		begin
			if (p == DEPTH - 1)
				ptr_inc = {AW{1'b0}};
			else
				ptr_inc = p + 1'b1;
		end
	endfunction

	assign in_ready_out  = (count_reg != DEPTH);
	assign out_valid_out = (count_reg != {(AW+1){1'b0}});
	assign out_data_out  = mem_reg[rd_ptr_reg];
	assign push          = in_valid_in & in_ready_out;
	assign pop           = out_valid_out & out_ready_in;

	always @(posedge clk_in) begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data_in;
	end

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr_reg <= ptr_inc(wr_ptr_reg);
			if (pop)
				rd_ptr_reg <= ptr_inc(rd_ptr_reg);
			if (push & ~pop)
				count_reg <= count_reg + 1'b1;
			else if (pop & ~push)
				count_reg <= count_reg - 1'b1;
		end
	end

endmodule

`default_nettype wire

/* scnr_host_if.v */
// Function
// - On each serial clock rise capture the input bit and update the output bit.
// - Serial clock is unrelated to the master clock; serial logic tracks it apart.
// - Select low frames a transfer; serial activity ignored while select is high.
// - Select affects only the serial port, nothing in scan or pixel paths.
// - Per-pixel gain comes from the 8-bit coefficient bus, bit 0 LSB; only when bit 7 at address 6 is set, else from address 5.
// - Device drives coefficient strobe and latches coefficient on its rising edge.
// - Each converted pixel is a 10-bit word on the pixel bus, bit 0 LSB.
// - End-of-conversion signals each new pixel placed in the output latch.
// - While read is low the output latch drives the pixel bus.
// - While read is high all ten pixel bus outputs float.
// - A low-to-high line sync transition starts a line scan.
// - Line sync returning low ends the scan; host holds it high meanwhile.
`include "scnr_map.vh"
`default_nettype none

module scnr_host_if #(
	parameter PIX_DIV    = `SCNR_PIX_DIV,
	parameter FIFO_DEPTH = `SCNR_FIFO_DEPTH
) (
	input  wire                    MCLK_IN,             // Master clock
	input  wire                    RESET_N_IN,          // Async reset, active low
	input  wire                    SER_CLK_IN,          // Serial clock pin
	input  wire                    SEL_N_IN,            // Serial select, active low
	input  wire                    SERIAL_IN_IN,        // Serial data in
	output reg                     SERIAL_OUT_OUT,      // Serial data out
	output reg                     SERIAL_OUT_OE_OUT,   // Serial out enable
	input  wire [`SCNR_COEF_W-1:0] GAIN_COEF_BUS_IN,    // Coefficient bus
	output reg                     COEF_STROBE_OUT,     // Coefficient clock
	output reg  [`SCNR_COEF_W-1:0] GAIN_OUT,            // Gain to PGA stage
	input  wire [`SCNR_PIX_W-1:0]  ADC_DATA_IN,         // Converter result
	output reg  [`SCNR_PIX_W-1:0]  PIXEL_OUT_BUS_OUT,   // Output latch
	output reg                     PIXEL_OUT_BUS_OE_OUT, // Pixel bus enable
	output reg                     CONV_DONE_OUT,       // New pixel pulse
	input  wire                    READ_N_IN,           // Read, active low
	input  wire                    LINE_SYNC_IN,        // Line scan sync
	output reg                     SCAN_ACTIVE_OUT,     // Scan in progress
	output reg                     OVERRUN_OUT          // Pixel slot held back by full FIFO
);

	localparam CW = `SCNR_PIX_CNT_W;
	localparam [CW-1:0] PIX_LAST = PIX_DIV - 1;
	localparam [CW-1:0] PIX_HALF = PIX_DIV / 2;

	localparam ST_IDLE = 1'b0;
	localparam ST_SCAN = 1'b1;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	reg [1:0] sclk_sync_reg;
	reg [1:0] sel_sync_reg;
	reg [1:0] sdin_sync_reg;
	reg [1:0] sync_sync_reg;
	reg [1:0] rd_sync_reg;
	reg [`SCNR_COEF_W-1:0] coef_meta_reg;
	reg [`SCNR_COEF_W-1:0] coef_sync_reg;
	reg       sclk_prev_reg;
	reg       sync_prev_reg;
	reg       rd_prev_reg;

	always @(posedge MCLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			sclk_sync_reg <= 2'h0;
			sel_sync_reg  <= 2'h3;
			sdin_sync_reg <= 2'h0;
			sync_sync_reg <= 2'h0;
			rd_sync_reg   <= 2'h3;
			coef_meta_reg <= 8'h00;
			coef_sync_reg <= 8'h00;
			sclk_prev_reg <= 1'b0;
			sync_prev_reg <= 1'b0;
			rd_prev_reg   <= 1'b1;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[0], SER_CLK_IN};
			sel_sync_reg  <= {sel_sync_reg[0], SEL_N_IN};
			sdin_sync_reg <= {sdin_sync_reg[0], SERIAL_IN_IN};
			sync_sync_reg <= {sync_sync_reg[0], LINE_SYNC_IN};
			rd_sync_reg   <= {rd_sync_reg[0], READ_N_IN};
			coef_meta_reg <= GAIN_COEF_BUS_IN;
			coef_sync_reg <= coef_meta_reg;
			sclk_prev_reg <= sclk_sync_reg[1];
			sync_prev_reg <= sync_sync_reg[1];
			rd_prev_reg   <= rd_sync_reg[1];
		end
	end

	wire sclk_rise = sclk_sync_reg[1] & ~sclk_prev_reg;
	wire sel_n     = sel_sync_reg[1];
	wire sync_rise = sync_sync_reg[1] & ~sync_prev_reg;
	wire sync_low  = ~sync_sync_reg[1];
	wire rd_n      = rd_sync_reg[1];
	wire rd_end    = rd_n & ~rd_prev_reg;

	// ----------------------------------------------------------------
	// Serial configuration port
	// ----------------------------------------------------------------
	reg [`SCNR_CFG_DW-1:0] cfg_mem_reg [0:`SCNR_CFG_DEPTH-1];
	reg [4:0]              bit_cnt_reg;
	reg [`SCNR_CFG_DW-1:0] shin_reg;
	reg [`SCNR_CFG_DW-1:0] shout_reg;
	reg                    rd_xfer_reg;
	reg [`SCNR_CFG_AW-1:0] addr_reg;
	wire [`SCNR_CFG_DW-1:0] shin_next = {shin_reg[`SCNR_CFG_DW-2:0], sdin_sync_reg[1]};
	integer i;

	always @(posedge MCLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			for (i = 0; i < `SCNR_CFG_DEPTH; i = i + 1)
				cfg_mem_reg[i] <= `SCNR_CFG_RST;
			bit_cnt_reg       <= 5'h00;
			shin_reg          <= 8'h00;
			shout_reg         <= 8'h00;
			rd_xfer_reg       <= 1'b0;
			addr_reg          <= 3'h0;
			SERIAL_OUT_OUT    <= 1'b0;
			SERIAL_OUT_OE_OUT <= 1'b0;
		end else if (sel_n) begin
			bit_cnt_reg       <= 5'h00;
			rd_xfer_reg       <= 1'b0;
			SERIAL_OUT_OE_OUT <= 1'b0;
		end else if (sclk_rise) begin
			shin_reg <= shin_next;
			if (bit_cnt_reg == `SCNR_FRAME_BITS - 5'h01)
				bit_cnt_reg <= 5'h00;
			else
				bit_cnt_reg <= bit_cnt_reg + 5'h01;
			if (bit_cnt_reg == `SCNR_HDR_BITS - 5'h01) begin
				addr_reg    <= shin_next[`SCNR_HDR_ADDR_MSB:0];
				rd_xfer_reg <= shin_next[`SCNR_HDR_RW_BIT];
				if (shin_next[`SCNR_HDR_RW_BIT]) begin
					SERIAL_OUT_OUT    <= cfg_mem_reg[shin_next[`SCNR_HDR_ADDR_MSB:0]][`SCNR_CFG_DW-1];
					shout_reg         <= {cfg_mem_reg[shin_next[`SCNR_HDR_ADDR_MSB:0]][`SCNR_CFG_DW-2:0], 1'b0};
					SERIAL_OUT_OE_OUT <= 1'b1;
				end
			end else if (bit_cnt_reg == `SCNR_FRAME_BITS - 5'h01) begin
				if (!rd_xfer_reg)
					cfg_mem_reg[addr_reg] <= shin_next;
				rd_xfer_reg       <= 1'b0;
				SERIAL_OUT_OE_OUT <= 1'b0;
			end else if (rd_xfer_reg) begin
				SERIAL_OUT_OUT <= shout_reg[`SCNR_CFG_DW-1];
				shout_reg      <= {shout_reg[`SCNR_CFG_DW-2:0], 1'b0};
			end
		end
	end

	// Serial state changes on detected serial clock edges and clears while select is high; the master clock
	// merely samples it, so any phase or rate below half the sample rate works.

	wire gain_from_bus = cfg_mem_reg[`SCNR_ADDR_GAINSRC][`SCNR_BIT_GAINSRC];
	wire [`SCNR_COEF_W-1:0] gain_fixed = cfg_mem_reg[`SCNR_ADDR_GAIN];

	// ----------------------------------------------------------------
	// Line scan control (select plays no part here)
	// ----------------------------------------------------------------
	reg          state_reg;
	reg [CW-1:0] pix_cnt_reg;
	wire         fifo_in_ready;
	wire         slot = (state_reg == ST_SCAN) && (pix_cnt_reg == {CW{1'b0}});

	always @(posedge MCLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			state_reg       <= ST_IDLE;
			pix_cnt_reg     <= {CW{1'b0}};
			SCAN_ACTIVE_OUT <= 1'b0;
			COEF_STROBE_OUT <= 1'b0;
			GAIN_OUT        <= 8'h00;
			OVERRUN_OUT     <= 1'b0;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				COEF_STROBE_OUT <= 1'b0;
				pix_cnt_reg     <= {CW{1'b0}};
				if (sync_rise) begin
					state_reg       <= ST_SCAN;
					SCAN_ACTIVE_OUT <= 1'b1;
					OVERRUN_OUT     <= 1'b0;
				end
			end
			ST_SCAN: begin
				if (sync_low) begin
					state_reg       <= ST_IDLE;
					SCAN_ACTIVE_OUT <= 1'b0;
					COEF_STROBE_OUT <= 1'b0;
				end else begin
					if (slot && !fifo_in_ready) begin
						OVERRUN_OUT <= 1'b1;
					end else begin
						if (pix_cnt_reg == PIX_LAST)
							pix_cnt_reg <= {CW{1'b0}};
						else
							pix_cnt_reg <= pix_cnt_reg + 1'b1;
					end
					if (slot && fifo_in_ready) begin
						COEF_STROBE_OUT <= 1'b1;
						if (gain_from_bus)
							GAIN_OUT <= coef_sync_reg;
						else
							GAIN_OUT <= gain_fixed;
					end else if (pix_cnt_reg == PIX_HALF) begin
						COEF_STROBE_OUT <= 1'b0;
					end
				end
			end
			default: begin
				state_reg       <= ST_IDLE;
				SCAN_ACTIVE_OUT <= 1'b0;
				COEF_STROBE_OUT <= 1'b0;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pixel buffer and output latch
	// ----------------------------------------------------------------
	wire                   fifo_out_valid;
	wire [`SCNR_PIX_W-1:0] fifo_out_data;
	reg                    latch_full_reg;
	wire                   latch_load = fifo_out_valid & ~latch_full_reg;

	scnr_fifo #(
		.W     (`SCNR_PIX_W),
		.DEPTH (FIFO_DEPTH),
		.AW    ($clog2(FIFO_DEPTH))
	) u_fifo (
		.clk_in        (MCLK_IN),
		.rst_n_in      (RESET_N_IN),
		.in_valid_in   (slot & ~sync_low),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (ADC_DATA_IN),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (~latch_full_reg),
		.out_data_out  (fifo_out_data)
	);

	always @(posedge MCLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			latch_full_reg       <= 1'b0;
			PIXEL_OUT_BUS_OUT    <= 10'h000;
			CONV_DONE_OUT        <= 1'b0;
			PIXEL_OUT_BUS_OE_OUT <= 1'b0;
		end else begin
			PIXEL_OUT_BUS_OE_OUT <= ~rd_n;
			CONV_DONE_OUT        <= latch_load;
			if (latch_load) begin
				PIXEL_OUT_BUS_OUT <= fifo_out_data;
				latch_full_reg    <= 1'b1;
			end else if (rd_end) begin
				latch_full_reg <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

/* scnr_host_if_chk.sv */
`default_nettype none
module scnr_host_if_chk #(
	parameter PIX_DIV = 8
) (
	input wire logic MCLK_IN,              // Clock
	input wire logic RESET_N_IN,           // Reset
	input wire logic SEL_N_IN,             // Select
	input wire logic READ_N_IN,            // Read
	input wire logic LINE_SYNC_IN,         // Sync
	input wire logic SERIAL_OUT_OE_OUT,    // Serial enable
	input wire logic COEF_STROBE_OUT,      // Strobe
	input wire logic CONV_DONE_OUT,        // New pixel
	input wire logic PIXEL_OUT_BUS_OE_OUT, // Bus enable
	input wire logic SCAN_ACTIVE_OUT       // Scan
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge MCLK_IN);
	endclocking
	default disable iff (!RESET_N_IN);
	// ------------------------------------------------------------
	// Assertions, strobe width assumes PIX_DIV of 8
	// ------------------------------------------------------------
	sequence s_pulse;
		$rose(COEF_STROBE_OUT) ##1 SCAN_ACTIVE_OUT[*4];
	endsequence
	sequence s_start;
		!SCAN_ACTIVE_OUT[*3] ##[1:3] SCAN_ACTIVE_OUT;
	endsequence
	pix_float_a: assert property (READ_N_IN[*4] |-> !PIXEL_OUT_BUS_OE_OUT)
		else $error("pixel bus driven while read high");
	pix_drive_a: assert property (!READ_N_IN[*4] |-> PIXEL_OUT_BUS_OE_OUT)
		else $error("pixel bus not driven while read low");
	ser_float_a: assert property (SEL_N_IN[*4] |-> !SERIAL_OUT_OE_OUT)
		else $error("serial out driven while deselected");
	done_pulse_a: assert property (CONV_DONE_OUT |=> !CONV_DONE_OUT)
		else $error("conversion flag longer than one cycle");
	strobe_scan_a: assert property (COEF_STROBE_OUT |-> SCAN_ACTIVE_OUT)
		else $error("strobe outside scan");
	strobe_width_a: assert property (s_pulse |-> !COEF_STROBE_OUT && $past(COEF_STROBE_OUT))
		else $error("strobe width wrong");
	scan_start_a: assert property ($rose(LINE_SYNC_IN) |-> s_start)
		else $error("scan start timing wrong");
	scan_end_a: assert property ($fell(LINE_SYNC_IN) |-> ##[3:6] !SCAN_ACTIVE_OUT)
		else $error("scan did not end");
endmodule

bind scnr_host_if scnr_host_if_chk #(.PIX_DIV(PIX_DIV)) scnr_host_if_chk_i (
	.MCLK_IN(MCLK_IN), .RESET_N_IN(RESET_N_IN), .SEL_N_IN(SEL_N_IN),
	.READ_N_IN(READ_N_IN), .LINE_SYNC_IN(LINE_SYNC_IN),
	.SERIAL_OUT_OE_OUT(SERIAL_OUT_OE_OUT), .COEF_STROBE_OUT(COEF_STROBE_OUT),
	.CONV_DONE_OUT(CONV_DONE_OUT), .PIXEL_OUT_BUS_OE_OUT(PIXEL_OUT_BUS_OE_OUT),
	.SCAN_ACTIVE_OUT(SCAN_ACTIVE_OUT)
);
`default_nettype wire

/* scnr_host_model.sv */
`default_nettype none
module scnr_host_model (
	input  wire logic clk,     // Master clock
	input  wire logic ser_out, // Device serial out
	input  wire logic ser_oe,  // Device drive enable
	output var  logic ser_clk, // Serial clock
	output var  logic sel_n,   // Select, active low
	output var  logic ser_in   // Serial data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last = 1'b0;
	logic line;
	// Released line shows the inverse of its last driven level
	assign line = ser_oe ? ser_out : ~last;
	always @(posedge clk)
		if (ser_oe) last <= ser_out;
	initial begin
		ser_clk = 1'b0;
		sel_n = 1'b1;
		ser_in = 1'b0;
	end
	// Frame of 16 bits, MSB first; clock offset from the master clock
	task xfer(input logic sel, input logic [15:0] f, output logic [7:0] rd);
		integer i;
		rd = 8'h00;
		@(posedge clk);
		sel_n <= ~sel;
		for (i = 0; i < 16; i++) begin
			ser_clk <= #3 1'b0;
			ser_in <= #3 f[15-i];
			repeat (8) @(posedge clk);
			if (i > 7)
				rd = {rd[6:0], line};
			ser_clk <= #3 1'b1;
			repeat (8) @(posedge clk);
		end
		ser_clk <= #3 1'b0;
		repeat (8) @(posedge clk);
		sel_n <= 1'b1;
		// Keep select high long enough for the device to see the gap
		repeat (4) @(posedge clk);
	endtask
endmodule
`default_nettype wire

/* test_scnr_host_if.sv */
`default_nettype none
module test_scnr_host_if;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] coef = 8'h00;
	logic [9:0] adc = 10'h000;
	logic read_n = 1'b1;
	logic sync = 1'b0;
	logic ser_clk, sel_n, ser_in, ser_out, ser_oe;
	logic strobe, done, pix_oe, scan, ovr;
	logic [7:0] gain;
	logic [7:0] rd;
	logic [9:0] pix;
	logic [15:0] e0;
	integer n_fail = 0;
	integer comparisons = 0;
	integer n_eoc = 0;

	scnr_host_if #(.PIX_DIV(8), .FIFO_DEPTH(4)) scnr_host_if_i (
		.MCLK_IN(mclk), .RESET_N_IN(rst_n), .SER_CLK_IN(ser_clk),
		.SEL_N_IN(sel_n), .SERIAL_IN_IN(ser_in), .SERIAL_OUT_OUT(ser_out),
		.SERIAL_OUT_OE_OUT(ser_oe), .GAIN_COEF_BUS_IN(coef),
		.COEF_STROBE_OUT(strobe), .GAIN_OUT(gain), .ADC_DATA_IN(adc),
		.PIXEL_OUT_BUS_OUT(pix), .PIXEL_OUT_BUS_OE_OUT(pix_oe),
		.CONV_DONE_OUT(done), .READ_N_IN(read_n), .LINE_SYNC_IN(sync),
		.SCAN_ACTIVE_OUT(scan), .OVERRUN_OUT(ovr)
	);
	scnr_host_model scnr_host_model_i (
		.clk(mclk), .ser_out(ser_out), .ser_oe(ser_oe),
		.ser_clk(ser_clk), .sel_n(sel_n), .ser_in(ser_in)
	);

	initial forever #5 mclk = ~mclk;
	always @(posedge mclk)
		if (done) n_eoc <= n_eoc + 1;

	task chk(input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task end_sim;
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Waits for the next rising edge of the strobe
	task wstb;
		integer k;
		k = 0;
		while (strobe && k < 50) begin
			tick(1);
			k++;
		end
		while (!strobe && k < 100) begin
			tick(1);
			k++;
		end
		chk(16'h0001, {15'h0, strobe});
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_serial;
		scnr_host_model_i.xfer(1'b1, 16'h05A5, rd);
		scnr_host_model_i.xfer(1'b1, 16'h0680, rd);
		scnr_host_model_i.xfer(1'b1, 16'h8500, rd);
		chk(16'h00A5, {8'h0, rd});
		scnr_host_model_i.xfer(1'b1, 16'h8600, rd);
		chk(16'h0080, {8'h0, rd});
		scnr_host_model_i.xfer(1'b0, 16'h0500, rd);
		scnr_host_model_i.xfer(1'b1, 16'h8500, rd);
		chk(16'h00A5, {8'h0, rd});
	endtask
	task rd_pix;
		@(posedge mclk);
		read_n <= 1'b0;
		tick(5);
		chk(16'h06B7, {5'h0, pix_oe, pix});
		@(posedge mclk);
		read_n <= 1'b1;
		tick(5);
		chk(16'h0000, {15'h0, pix_oe});
	endtask
	task t_scan;
		@(posedge mclk);
		coef <= 8'h5A;
		adc <= 10'h2B7;
		sync <= 1'b1;
		wstb;
		chk(16'h005A, {8'h0, gain});
		@(posedge mclk);
		coef <= 8'hC3;
		wstb;
		chk(16'h00C3, {8'h0, gain});
		scnr_host_model_i.xfer(1'b1, 16'h8500, rd);
		chk(16'h00A5, {8'h0, rd});
		chk(16'h0003, {14'h0, scan, ovr});
		@(posedge mclk);
		sync <= 1'b0;
		tick(8);
		chk(16'h0000, {14'h0, scan, strobe});
		e0 = n_eoc[15:0];
		repeat (5) rd_pix;
		chk(16'h0004, n_eoc[15:0] - e0);
	endtask
	// Fixed gain source: the coefficient bus must not reach the gain
	task t_fixed;
		scnr_host_model_i.xfer(1'b1, 16'h0600, rd);
		@(posedge mclk);
		coef <= 8'h3C;
		sync <= 1'b1;
		wstb;
		chk(16'h00A5, {8'h0, gain});
		chk(16'h0002, {14'h0, scan, ovr});
		@(posedge mclk);
		sync <= 1'b0;
		tick(8);
		chk(16'h0000, {14'h0, scan, strobe});
	endtask

	initial begin
		#200000;
		n_fail++;
		end_sim;
	end
	initial begin
		tick(3);
		chk(16'h0000, {10'h0, scan, strobe, done, pix_oe, ser_oe, ovr});
		@(posedge mclk);
		rst_n <= 1'b1;
		tick(2);
		t_serial;
		t_scan;
		t_fixed;
		end_sim;
	end
endmodule
`default_nettype wire
